// ==== hw/atb_pkg.sv ====
// Constants for the area translation buffers of the data and instruction MMUs.
// Assumes a single 40 MHz clock domain shared with the core that drives lookups.
package atb_pkg;

  // ****************************************************************
  // Entry selection on the special-register port
  // ****************************************************************
  localparam logic [1:0] ATB_SEL_DMATCH  = 2'h0;
  localparam logic [1:0] ATB_SEL_DTRANS  = 2'h1;
  localparam logic [1:0] ATB_SEL_IMATCH  = 2'h2;
  localparam logic [1:0] ATB_SEL_ITRANS  = 2'h3;
  localparam int         ATB_SEL_LSB     = 2;

  // ****************************************************************
  // Match word fields
  // ****************************************************************
  localparam int ATB_VPN_LSB   = 10;
  localparam int ATB_CTX_MSB   = 5;
  localparam int ATB_CTX_LSB   = 2;
  localparam int ATB_VALID_BIT = 0;
  localparam logic [31:0] ATB_MATCH_CTX_MASK = 32'hFFFF_FFC3;

  // ****************************************************************
  // Translate word fields
  // ****************************************************************
  localparam int ATB_PPN_LSB   = 10;
  localparam int ATB_CC_BIT    = 0;
  localparam int ATB_CI_BIT    = 1;
  localparam int ATB_WBC_BIT   = 2;
  localparam int ATB_WOM_BIT   = 3;
  localparam int ATB_ACC_BIT   = 4;
  localparam int ATB_DIRTY_BIT = 5;
  localparam int ATB_URE_BIT   = 6;
  localparam int ATB_UWE_BIT   = 7;
  localparam int ATB_SRE_BIT   = 8;
  localparam int ATB_SWE_BIT   = 9;
  localparam int ATB_SXE_BIT   = 6;
  localparam int ATB_UXE_BIT   = 7;
  localparam logic [31:0] ATB_ITRANS_MASK = 32'hFFFF_FCFF;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] ATB_WORD_RST = 32'h0000_0000;

endpackage : atb_pkg

// ==== hw/atb_top.sv ====
// Four-entry data and instruction area translation buffers with their
// special-register access port. Lookups and register moves come from core logic
// on the same clock, so no input is synchronised.

// Operation
// - Inhibit bit of the hit entry makes the page bypass the cache.
// - Write-back select bit picks write-back (1) or write-through (0).
// - Weak order bit picks weakly (1) or strongly (0) ordered handling.
// - Each translate word carries an accessed flag, set when the page is used.
// - Each data translate word carries a dirty flag, set when the page is stored.
// - Supervisor execute bit allows or forbids supervisor fetches from the page.
// - User execute bit allows or forbids user fetches from the page.
// - Physical frame number forms the upper bits of the translated address.
// - Entries are 32-bit words moved only by supervisor register moves.
// - Four data and four instruction entries, each a match and translate word.
// - Match word bits 31-10 hold the virtual page tag compared on lookup.
// - Lookup address joins the effective address and the current context tag.
// - Without fast context switching the match context bits read as zero.
// - Supervisor and user read bits allow or forbid loads per mode.
// - Supervisor and user write bits allow or forbid stores per mode.
// - Coherency bit asks for data cache coherency on the page.
// - Data entries serve load/store only, instruction entries serve fetch only.
// - A hit whose permission bits forbid the access raises a page fault.
module atb_top
  import atb_pkg::*;
#(
  parameter int ENTRIES = 4,
  parameter bit CTX_EN  = 1'b1
)(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        sup_mode,
  input  wire logic [3:0]  context_tag,
  input  wire logic        spr_we,
  input  wire logic        spr_re,
  input  wire logic [3:0]  spr_addr,
  input  wire logic [31:0] spr_wdata,
  output logic [31:0]      spr_rdata,
  output logic             spr_ack,
  output logic             spr_priv_err,
  input  wire logic        d_req,
  input  wire logic        d_store,
  input  wire logic [31:0] d_eff_addr,
  output logic             d_ack,
  output logic             d_hit,
  output logic [31:0]      d_paddr,
  output logic             d_cache_inhibit,
  output logic             d_write_back,
  output logic             d_weak_order,
  output logic             d_coherency,
  output logic             d_page_fault,
  input  wire logic        i_req,
  input  wire logic [31:0] i_eff_addr,
  output logic             i_ack,
  output logic             i_hit,
  output logic [31:0]      i_paddr,
  output logic             i_cache_inhibit,
  output logic             i_weak_order,
  output logic             i_page_fault
);

  localparam int IW = $clog2(ENTRIES);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic atb_match(input logic [31:0] mw, input logic [31:0] ea,
                                     input logic [3:0] ctx);
    logic ctx_ok;
    ctx_ok = CTX_EN ? (mw[ATB_CTX_MSB:ATB_CTX_LSB] == ctx) : 1'b1;
    return mw[ATB_VALID_BIT] && (mw[31:ATB_VPN_LSB] == ea[31:ATB_VPN_LSB])
           && ctx_ok;
  endfunction

  // Lowest index wins when software left overlapping areas
  function automatic logic [IW-1:0] atb_first(input logic [ENTRIES-1:0] v);
    logic [IW-1:0] idx;
    idx = '0;
    for (int k = ENTRIES - 1; k >= 0; k--)
    begin
      if (v[k])
      begin
        idx = IW'(k);
      end
    end
    return idx;
  endfunction

  // ****************************************************************
  // Entry storage; contents are left unreset, software loads them
  // ****************************************************************
  logic [31:0] dmatch_r [ENTRIES];
  logic [31:0] dtrans_r [ENTRIES];
  logic [31:0] imatch_r [ENTRIES];
  logic [31:0] itrans_r [ENTRIES];

  // ****************************************************************
  // Register move decode
  // ****************************************************************
  wire logic [1:0]    spr_sel    = spr_addr[ATB_SEL_LSB+1:ATB_SEL_LSB];
  wire logic [IW-1:0] spr_idx    = spr_addr[IW-1:0];
  wire logic          spr_wr_ok  = spr_we && sup_mode;
  wire logic [31:0]   match_wval = CTX_EN ? spr_wdata
                                          : (spr_wdata & ATB_MATCH_CTX_MASK);
  wire logic [31:0]   itr_wval   = spr_wdata & ATB_ITRANS_MASK;

  // ****************************************************************
  // Data lookup, load/store only
  // ****************************************************************
  logic [ENTRIES-1:0] d_hitv;
  logic [ENTRIES-1:0] i_hitv;
  logic [ENTRIES-1:0] d_set_acc;
  logic [ENTRIES-1:0] d_set_dirty;
  logic [ENTRIES-1:0] i_set_acc;

  wire logic          d_any  = |d_hitv;
  wire logic [IW-1:0] d_idx  = atb_first(d_hitv);
  wire logic [31:0]   d_tw   = dtrans_r[d_idx];
  wire logic          d_rd_ok = sup_mode ? d_tw[ATB_SRE_BIT] : d_tw[ATB_URE_BIT];
  wire logic          d_wr_ok = sup_mode ? d_tw[ATB_SWE_BIT] : d_tw[ATB_UWE_BIT];
  wire logic          d_perm = d_store ? d_wr_ok : d_rd_ok;
  wire logic          d_go   = d_req && d_any && d_perm;
  wire logic          d_flt  = d_req && d_any && !d_perm;

  // ****************************************************************
  // Instruction lookup, fetch only
  // ****************************************************************
  wire logic          i_any  = |i_hitv;
  wire logic [IW-1:0] i_idx  = atb_first(i_hitv);
  wire logic [31:0]   i_tw   = itrans_r[i_idx];
  wire logic          i_perm = sup_mode ? i_tw[ATB_SXE_BIT]
                                        : i_tw[ATB_UXE_BIT];
  wire logic          i_go   = i_req && i_any && i_perm;
  wire logic          i_flt  = i_req && i_any && !i_perm;

  for (genvar g = 0; g < ENTRIES; g++)
  begin : g_ent
    assign d_hitv[g]      = atb_match(dmatch_r[g], d_eff_addr, context_tag);
    assign i_hitv[g]      = atb_match(imatch_r[g], i_eff_addr, context_tag);
    assign d_set_acc[g]   = d_go && (d_idx == IW'(g));
    assign d_set_dirty[g] = d_set_acc[g] && d_store;
    assign i_set_acc[g]   = i_go && (i_idx == IW'(g));
  end

  // ****************************************************************
  // Entry writes; a hardware flag set is ORed over a same-cycle move
  // so a page use is never lost
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    for (int k = 0; k < ENTRIES; k++)
    begin
      if (spr_wr_ok && spr_sel == ATB_SEL_DMATCH && spr_idx == IW'(k))
      begin
        dmatch_r[k] <= match_wval;
      end
      if (spr_wr_ok && spr_sel == ATB_SEL_IMATCH && spr_idx == IW'(k))
      begin
        imatch_r[k] <= match_wval;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    for (int k = 0; k < ENTRIES; k++)
    begin
      if (spr_wr_ok && spr_sel == ATB_SEL_DTRANS && spr_idx == IW'(k))
      begin
        dtrans_r[k] <= spr_wdata | (32'(d_set_acc[k]) << ATB_ACC_BIT)
                                 | (32'(d_set_dirty[k]) << ATB_DIRTY_BIT);
      end
      else
      begin
        dtrans_r[k] <= dtrans_r[k] | (32'(d_set_acc[k]) << ATB_ACC_BIT)
                                   | (32'(d_set_dirty[k]) << ATB_DIRTY_BIT);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    for (int k = 0; k < ENTRIES; k++)
    begin
      if (spr_wr_ok && spr_sel == ATB_SEL_ITRANS && spr_idx == IW'(k))
      begin
        itrans_r[k] <= itr_wval | (32'(i_set_acc[k]) << ATB_ACC_BIT);
      end
      else
      begin
        itrans_r[k] <= itrans_r[k] | (32'(i_set_acc[k]) << ATB_ACC_BIT);
      end
    end
  end

  // ****************************************************************
  // Register move read-back; user-mode moves are refused
  // ****************************************************************
  logic [31:0] spr_mux;

  always_comb
  begin
    unique case (spr_sel)
      ATB_SEL_DMATCH: spr_mux = dmatch_r[spr_idx];
      ATB_SEL_DTRANS: spr_mux = dtrans_r[spr_idx];
      ATB_SEL_IMATCH: spr_mux = imatch_r[spr_idx];
      ATB_SEL_ITRANS: spr_mux = itrans_r[spr_idx];
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      spr_rdata    <= ATB_WORD_RST;
      spr_ack      <= 1'b0;
      spr_priv_err <= 1'b0;
    end
    else
    begin
      spr_ack      <= spr_we || spr_re;
      spr_priv_err <= (spr_we || spr_re) && !sup_mode;
      spr_rdata    <= (spr_re && sup_mode) ? spr_mux : ATB_WORD_RST;
    end
  end

  // ****************************************************************
  // Data lookup answer, one cycle after the request
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      d_ack           <= 1'b0;
      d_hit           <= 1'b0;
      d_page_fault    <= 1'b0;
      d_paddr         <= ATB_WORD_RST;
      d_cache_inhibit <= 1'b0;
      d_write_back    <= 1'b0;
      d_weak_order    <= 1'b0;
      d_coherency     <= 1'b0;
    end
    else
    begin
      d_ack           <= d_req;
      d_hit           <= d_req && d_any;
      d_page_fault    <= d_flt;
      d_paddr         <= {d_tw[31:ATB_PPN_LSB], d_eff_addr[ATB_PPN_LSB-1:0]};
      d_cache_inhibit <= d_tw[ATB_CI_BIT];
      d_write_back    <= d_tw[ATB_WBC_BIT];
      d_weak_order    <= d_tw[ATB_WOM_BIT];
      d_coherency     <= d_tw[ATB_CC_BIT];
    end
  end

  // ****************************************************************
  // Instruction lookup answer, one cycle after the request
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      i_ack           <= 1'b0;
      i_hit           <= 1'b0;
      i_page_fault    <= 1'b0;
      i_paddr         <= ATB_WORD_RST;
      i_cache_inhibit <= 1'b0;
      i_weak_order    <= 1'b0;
    end
    else
    begin
      i_ack           <= i_req;
      i_hit           <= i_req && i_any;
      i_page_fault    <= i_flt;
      i_paddr         <= {i_tw[31:ATB_PPN_LSB], i_eff_addr[ATB_PPN_LSB-1:0]};
      i_cache_inhibit <= i_tw[ATB_CI_BIT];
      i_weak_order    <= i_tw[ATB_WOM_BIT];
    end
  end

endmodule // atb_top

// ==== tb/atb_core_model.sv ====
// Load/store and fetch unit model that issues one lookup at a time.
// Assumes the caller samples the answer at the falling edge on which the task returns.
module atb_core_model (
  input  wire logic        clk,
  output logic             d_req,
  output logic             d_store,
  output logic [31:0]      d_eff_addr,
  output logic             i_req,
  output logic [31:0]      i_eff_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {d_req, d_store, i_req} = 3'h0;
    d_eff_addr = 32'h0000_0000;
    i_eff_addr = 32'h0000_0000;
  end
  // Fetches go to the fetch side only, loads and stores to the data side only
  task automatic lookup(input logic insn, input logic store, input logic [31:0] ea);
    @(negedge clk);
    i_req = insn;
    d_req = !insn;
    d_store = store && !insn;
    d_eff_addr = ea;
    i_eff_addr = ea;
    @(negedge clk);
    {d_req, d_store, i_req} = 3'h0;
    // Stale address would hide a design that samples late
    d_eff_addr = ~ea;
    i_eff_addr = ~ea;
  endtask
endmodule // atb_core_model

// ==== tb/atb_props.sv ====
// Port-level assertions for the area translation buffers.
// Assumes it is bound to atb_top and shares its clock and reset.
module atb_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        sup_mode,
  input wire logic        spr_we,
  input wire logic        spr_re,
  input wire logic [31:0] spr_rdata,
  input wire logic        spr_ack,
  input wire logic        spr_priv_err,
  input wire logic        d_req,
  input wire logic [31:0] d_eff_addr,
  input wire logic        d_ack,
  input wire logic        d_hit,
  input wire logic [31:0] d_paddr,
  input wire logic        d_page_fault,
  input wire logic        i_req,
  input wire logic        i_ack,
  input wire logic        i_hit,
  input wire logic        i_page_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  move_ack_a : assert property ((spr_we || spr_re) |=> spr_ack)
    else $error("register move got no ack");
  stray_ack_a : assert property (!spr_we && !spr_re |=> !spr_ack)
    else $error("ack without a register move");
  user_move_a : assert property ((spr_we || spr_re) && !sup_mode |=> spr_priv_err && spr_rdata == 32'h0000_0000)
    else $error("user mode move not refused");
  read_quiet_a : assert property (spr_ack && !($past(spr_re) && $past(sup_mode)) |-> spr_rdata == 32'h0000_0000)
    else $error("read data without supervisor read");
  data_ack_a : assert property (d_req |=> d_ack)
    else $error("data lookup not answered");
  fetch_ack_a : assert property (i_req |=> i_ack)
    else $error("fetch lookup not answered");
  data_fault_a : assert property (d_page_fault |-> d_hit && d_ack)
    else $error("data fault without a hit");
  fetch_fault_a : assert property (i_page_fault |-> i_hit && i_ack)
    else $error("fetch fault without a hit");
  page_offset_a : assert property (d_ack && d_hit |-> ((d_paddr ^ $past(d_eff_addr)) & 32'h0000_03FF) == 32'h0000_0000)
    else $error("page offset not carried through");
endmodule // atb_props

bind atb_top atb_props u_props (.clk, .rstn, .sup_mode, .spr_we, .spr_re, .spr_rdata, .spr_ack,
  .spr_priv_err, .d_req, .d_eff_addr, .d_ack, .d_hit, .d_paddr, .d_page_fault, .i_req, .i_ack,
  .i_hit, .i_page_fault);

// ==== tb/test_area_translation_buffer.sv ====
// Self-checking bench for the area translation buffers.
// Assumes atb_top with four entries per side and context matching on.
module test_area_translation_buffer
  import atb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, sup_mode, spr_we, spr_re, spr_ack, spr_priv_err;
  logic [3:0]  context_tag, spr_addr;
  logic [31:0] spr_wdata, spr_rdata, d_eff_addr, d_paddr, i_eff_addr, i_paddr;
  logic        d_req, d_store, d_ack, d_hit, d_cache_inhibit, d_write_back, d_weak_order;
  logic        d_coherency, d_page_fault, i_req, i_ack, i_hit, i_cache_inhibit;
  logic        i_weak_order, i_page_fault;
  int          error_cnt, n_checks;
  localparam logic [31:0] EA = 32'h1234_5677;

  atb_top DUT (.clk, .rstn, .sup_mode, .context_tag, .spr_we, .spr_re, .spr_addr, .spr_wdata,
    .spr_rdata, .spr_ack, .spr_priv_err, .d_req, .d_store, .d_eff_addr, .d_ack, .d_hit,
    .d_paddr, .d_cache_inhibit, .d_write_back, .d_weak_order, .d_coherency, .d_page_fault,
    .i_req, .i_eff_addr, .i_ack, .i_hit, .i_paddr, .i_cache_inhibit, .i_weak_order,
    .i_page_fault);
  atb_core_model core (.clk, .d_req, .d_store, .d_eff_addr, .i_req, .i_eff_addr);

  always #12.5 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic move(input logic wr, input logic [1:0] sel, input logic [1:0] idx,
                      input logic [31:0] data);
    @(negedge clk);
    spr_we = wr;
    spr_re = !wr;
    spr_addr = {sel, idx};
    spr_wdata = data;
    @(negedge clk);
    spr_we = 1'b0;
    spr_re = 1'b0;
    spr_wdata = ~data;
  endtask
  task automatic rd(input logic [1:0] sel, input logic [1:0] idx, input logic [31:0] exp);
    move(1'b0, sel, idx, 32'h0000_0000);
    check("spr_ack", spr_ack, 32'h0000_0001);
    check("spr_rdata", spr_rdata, exp);
  endtask
  // Expected tuple is {ack, hit, fault}
  task automatic look(input logic insn, input logic st, input logic [31:0] ea,
                      input logic [2:0] hf, input logic [31:0] pa);
    core.lookup(insn, st, ea);
    check("ack_hit_fault", insn ? {i_ack, i_hit, i_page_fault} : {d_ack, d_hit, d_page_fault}, hf);
    if (hf[1])
      check("paddr", insn ? i_paddr : d_paddr, pa);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    {clk, rstn, spr_we, spr_re} = 4'h0;
    sup_mode = 1'b1;
    context_tag = 4'hD;
    spr_addr = 4'h0;
    spr_wdata = 32'h0000_0000;
    repeat (5) @(negedge clk);
    check("idle_outputs", {spr_ack, d_ack, i_ack}, 32'h0000_0000);
    rstn = 1'b1;
    for (int k = 0; k < 16; k++)
      move(1'b1, k[3:2], k[1:0], 32'h0000_0000);
    move(1'b1, ATB_SEL_DMATCH, 2'h2, 32'h1234_5435);
    rd(ATB_SEL_DMATCH, 2'h2, 32'h1234_5435);
    move(1'b1, ATB_SEL_ITRANS, 2'h1, 32'hFFFF_FFFF);
    rd(ATB_SEL_ITRANS, 2'h1, 32'hFFFF_FCFF);
    sup_mode = 1'b0;
    move(1'b1, ATB_SEL_DTRANS, 2'h2, 32'hFFFF_FFFF);
    check("priv_err", spr_priv_err, 32'h0000_0001);
    rd(ATB_SEL_DTRANS, 2'h2, 32'h0000_0000);
    sup_mode = 1'b1;
    rd(ATB_SEL_DTRANS, 2'h2, 32'h0000_0000);
    move(1'b1, ATB_SEL_DTRANS, 2'h2, 32'hABCD_E10B);
    look(1'b0, 1'b0, EA, 3'h6, 32'hABCD_E277);
    check("d_attr", {d_cache_inhibit, d_write_back, d_weak_order, d_coherency}, 4'hB);
    rd(ATB_SEL_DTRANS, 2'h2, 32'hABCD_E11B);
    look(1'b0, 1'b1, EA, 3'h7, 32'hABCD_E277);
    rd(ATB_SEL_DTRANS, 2'h2, 32'hABCD_E11B);
    context_tag = 4'hC;
    look(1'b0, 1'b0, EA, 3'h4, 32'h0000_0000);
    context_tag = 4'hD;
    look(1'b1, 1'b0, EA, 3'h4, 32'h0000_0000);
    // Attribute bits flipped against the first entry so no output can sit stuck
    move(1'b1, ATB_SEL_DTRANS, 2'h2, 32'hABCD_E304);
    look(1'b0, 1'b1, EA, 3'h6, 32'hABCD_E277);
    check("d_attr", {d_cache_inhibit, d_write_back, d_weak_order, d_coherency}, 4'h4);
    rd(ATB_SEL_DTRANS, 2'h2, 32'hABCD_E334);
    sup_mode = 1'b0;
    look(1'b0, 1'b0, EA, 3'h7, 32'hABCD_E277);
    move(1'b1, ATB_SEL_IMATCH, 2'h0, 32'h0040_0035);
    sup_mode = 1'b1;
    move(1'b1, ATB_SEL_IMATCH, 2'h0, 32'h0040_0035);
    move(1'b1, ATB_SEL_ITRANS, 2'h0, 32'h0080_0082);
    sup_mode = 1'b0;
    look(1'b1, 1'b0, 32'h0040_0123, 3'h6, 32'h0080_0123);
    check("i_attr", {i_cache_inhibit, i_weak_order}, 2'h2);
    look(1'b0, 1'b0, 32'h0040_0123, 3'h4, 32'h0000_0000);
    sup_mode = 1'b1;
    look(1'b1, 1'b0, 32'h0040_0123, 3'h7, 32'h0080_0123);
    rd(ATB_SEL_ITRANS, 2'h0, 32'h0080_0092);
    tally_and_finish;
  end
  // Whole sequence is under 200 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule // test_area_translation_buffer
